// *** design/sbrg_gate.sv ***
// Step and burst readout gate with message position counter
`include "sbrg_defines.svh"
`default_nettype none

module sbrg_gate (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 step_request_input,
  input  wire logic                 burst_request_input,
  input  wire sbrg_pkg::sbrg_mode_t mode,
  input  wire logic [6:0]           msg_length,
  input  wire logic                 char_read_done,
  output logic                      readout_permit_gate,
  output logic                      counter_reset,
  output sbrg_pkg::sbrg_pos_t       position
);

  // ----------------------------------------------------------------
  // Request synchronisers
  // ----------------------------------------------------------------
  sbrg_pkg::sbrg_req_t sync1_r;
  sbrg_pkg::sbrg_req_t sync1_nxt;
  sbrg_pkg::sbrg_req_t sync2_r;
  sbrg_pkg::sbrg_req_t sync2_nxt;
  sbrg_pkg::sbrg_req_t prev_r;
  sbrg_pkg::sbrg_req_t prev_nxt;
  logic                step_edge;
  logic                burst_edge;

  always_comb begin
    sync1_nxt = sbrg_pkg::sbrg_req_t'({step_request_input, burst_request_input});
    sync2_nxt = sync1_r;
    prev_nxt  = sync2_r;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= sbrg_pkg::sbrg_req_t'(`SBRG_SYNC_RST);
      sync2_r <= sbrg_pkg::sbrg_req_t'(`SBRG_SYNC_RST);
      prev_r  <= sbrg_pkg::sbrg_req_t'(`SBRG_SYNC_RST);
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r  <= prev_nxt;
    end
  end

  // Edge only, so a held step line releases a single character
  assign step_edge  = sync2_r.step & ~prev_r.step;
  assign burst_edge = sync2_r.burst & ~prev_r.burst;

  // ----------------------------------------------------------------
  // Message position counter
  // ----------------------------------------------------------------
  sbrg_pkg::sbrg_pos_t pos_r;
  sbrg_pkg::sbrg_pos_t pos_nxt;
  logic [6:0]          pos_index;
  logic [6:0]          last_index;
  logic                msg_end;

  assign pos_index = 7'({3'h0, pos_r.tens} * `SBRG_DIGIT_BASE) + {3'h0, pos_r.units};

  // Digit limits must match the longest message, or the wrap skips a count
  if ((int'(`SBRG_TENS_LAST) * 10 + int'(`SBRG_UNITS_LAST) + 1) != int'(`SBRG_MSG_MAX)) begin : g_len_chk
    $error("Digit limits disagree with the longest message");
  end

  // Out-of-range lengths fall back to the longest message
  assign last_index = ((msg_length == 7'h00) || (msg_length > `SBRG_MSG_MAX)) ?
                      (`SBRG_MSG_MAX - 7'h01) : (msg_length - 7'h01);

  assign msg_end       = char_read_done && (pos_index == last_index);
  assign counter_reset = msg_end;

  always_comb begin
    pos_nxt = pos_r;
    if (msg_end) begin
      pos_nxt.tens  = `SBRG_DIGIT_RST;
      pos_nxt.units = `SBRG_DIGIT_RST;
    end else if (char_read_done) begin
      if (pos_r.units == `SBRG_UNITS_LAST) begin
        pos_nxt.units = `SBRG_DIGIT_RST;
        pos_nxt.tens  = (pos_r.tens == `SBRG_TENS_LAST) ? `SBRG_DIGIT_RST : pos_r.tens + 4'h1;
      end else begin
        pos_nxt.units = pos_r.units + 4'h1;
      end
    end
  end

  // Power-up zeroing comes through the asynchronous reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pos_r <= sbrg_pkg::sbrg_pos_t'({`SBRG_DIGIT_RST, `SBRG_DIGIT_RST});
    end else begin
      pos_r <= pos_nxt;
    end
  end

  assign position = pos_r;

  // ----------------------------------------------------------------
  // Step pending flag and burst latch
  // ----------------------------------------------------------------
  logic step_pend_r;
  logic step_pend_nxt;
  logic burst_latch_r;
  logic burst_latch_nxt;
  logic burst_mode;

  assign burst_mode = (mode == sbrg_pkg::SBRG_MODE_BURST);

  always_comb begin
    step_pend_nxt = step_pend_r;
    if (burst_mode) begin
      step_pend_nxt = 1'b0;
    end else if (step_edge) begin
      step_pend_nxt = 1'b1;
    end else if (char_read_done) begin
      step_pend_nxt = 1'b0;
    end
  end

  // A new request in the cycle of the clear wins over it
  always_comb begin
    burst_latch_nxt = burst_latch_r;
    if (!burst_mode) begin
      burst_latch_nxt = 1'b0;
    end else if (burst_edge) begin
      burst_latch_nxt = 1'b1;
    end else if (counter_reset) begin
      burst_latch_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      step_pend_r   <= 1'b0;
      burst_latch_r <= 1'b0;
    end else begin
      step_pend_r   <= step_pend_nxt;
      burst_latch_r <= burst_latch_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Readout permit gate
  // ----------------------------------------------------------------
  // Combinational so the register sees the permit without extra lag
  assign readout_permit_gate = burst_mode ? burst_latch_r : step_pend_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  step_permit_a: assert property (
    (!burst_mode && step_edge) |=> (readout_permit_gate || burst_mode))
    else $error("Step request did not open the readout permit");

  burst_blocked_a: assert property (
    (!burst_mode && sync2_r.burst) |=> !burst_latch_r)
    else $error("Burst latch set while in step mode");

  one_char_a: assert property (
    (!burst_mode && step_pend_r && char_read_done && !step_edge) |=> !readout_permit_gate || burst_mode)
    else $error("Step permit outlived its single character");

  burst_only_a: assert property (
    burst_mode |-> (readout_permit_gate == burst_latch_r))
    else $error("Step path influenced the gate in burst mode");

  burst_set_a: assert property (
    (burst_mode && burst_edge) ##1 burst_mode |-> burst_latch_r)
    else $error("Burst request did not set the latch");

  burst_hold_a: assert property (
    (burst_latch_r && !counter_reset && burst_mode) ##1 burst_mode |-> readout_permit_gate)
    else $error("Permit dropped while burst latch was set");

  msg_stop_a: assert property (
    (burst_mode && counter_reset && !burst_edge) |=> !readout_permit_gate)
    else $error("Sending did not stop at message end");

  pos_zero_a: assert property (
    counter_reset |=> (pos_index == 7'h00))
    else $error("Counters not zeroed at message end");

  pos_step_a: assert property (
    (char_read_done && !msg_end && pos_index != 7'h4F) |=> (pos_index == $past(pos_index) + 7'h01))
    else $error("Position did not advance by one");

  pos_hold_a: assert property (
    !char_read_done |=> $stable(pos_r))
    else $error("Position moved without a character read");

  step_once_a: assert property (
    step_edge |=> !step_edge [*2])
    else $error("Held step request produced repeated edges");

  init_pos_a: assert property (
    $rose(reset_n) |-> (pos_index == 7'h00))
    else $error("Position not zero after power-up");

  pos_wrap_a: assert property (
    (char_read_done && !msg_end && pos_index == 7'h4F) |=> (pos_index == 7'h00))
    else $error("Position did not wrap after the last slot");

  permit_cause_a: assert property (
    $rose(readout_permit_gate) |-> ($past(step_edge) || $past(burst_edge)))
    else $error("Readout permit opened without a request edge");

endmodule // sbrg_gate
`default_nettype wire

// *** common/sbrg_defines.svh ***
// Constants for the step and burst readout gate
`ifndef SBRG_DEFINES_SVH
`define SBRG_DEFINES_SVH

// ----------------------------------------------------------------
// Message position limits
// ----------------------------------------------------------------
`define SBRG_UNITS_LAST 4'h9
`define SBRG_TENS_LAST  4'h7
`define SBRG_MSG_MAX    7'h50
`define SBRG_DIGIT_BASE 7'h0A

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SBRG_DIGIT_RST  4'h0
`define SBRG_SYNC_RST   2'h0

`endif

// *** common/sbrg_pkg.sv ***
// Types shared by the step and burst readout gate
`default_nettype none
package sbrg_pkg;

  // Message position as two decimal digits
  typedef struct packed {
    logic [3:0] tens;
    logic [3:0] units;
  } sbrg_pos_t;

  // Synchronised external requests
  typedef struct packed {
    logic step;
    logic burst;
  } sbrg_req_t;

  // Operating mode of the gate
  typedef enum logic {
    SBRG_MODE_STEP,
    SBRG_MODE_BURST
  } sbrg_mode_t;

endpackage
`default_nettype wire

// *** verification/sbrg_ctrl_model.sv ***
// Output register stand-in that reads characters while permit is open
`default_nettype none
module sbrg_ctrl_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       readout_permit_gate,
  input  wire logic [1:0] slow,
  output var  logic       char_read_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt = 0;
  initial char_read_done = 1'b0;
  // Random hold-off; the pulse lasts one cycle so one read is one character
  always @(negedge clk) begin
    if (!reset_n || char_read_done) begin
      char_read_done = 1'b0;
      wait_cnt = 0;
    end else if (readout_permit_gate && wait_cnt >= slow) begin
      char_read_done = 1'b1;
    end else if (readout_permit_gate) begin
      wait_cnt++;
    end
  end
endmodule // sbrg_ctrl_model
`default_nettype wire

// *** verification/sbrg_gate_test.sv ***
// Self-checking bench for the step and burst readout gate
`default_nettype none
module sbrg_gate_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic step_request_input = 1'b0;
  logic burst_request_input = 1'b0;
  sbrg_pkg::sbrg_mode_t mode = sbrg_pkg::SBRG_MODE_STEP;
  logic [6:0] msg_length = 7'h05;
  logic [1:0] slow = 2'h0;
  logic char_read_done;
  logic readout_permit_gate;
  logic counter_reset;
  sbrg_pkg::sbrg_pos_t position;
  int error_cnt = 0;
  int total_checks = 0;
  int idx = 0;
  int chars = 0;
  logic [31:0] seed = 32'h6AB0;
  logic [6:0] lens [6] = '{7'h01, 7'h08, 7'h50, 7'h00, 7'h64, 7'h0A};

  sbrg_gate dut (.clk(clk), .reset_n(reset_n), .step_request_input(step_request_input),
    .burst_request_input(burst_request_input), .mode(mode), .msg_length(msg_length),
    .char_read_done(char_read_done), .readout_permit_gate(readout_permit_gate),
    .counter_reset(counter_reset), .position(position));
  sbrg_ctrl_model partner (.clk(clk), .reset_n(reset_n), .readout_permit_gate(readout_permit_gate),
    .slow(slow), .char_read_done(char_read_done));

  always #10 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Lengths out of range behave as a full message
  function automatic int len_of(logic [6:0] m);
    return (m == 7'h00 || m > 7'h50) ? 80 : int'(m);
  endfunction

  task automatic end_sim();
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_bit(logic got, logic exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_int(int got, int exp);
    total_checks++;
    if (got != exp) begin
      error_cnt++;
      $display("Error %0t count got %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic chk_pos(sbrg_pkg::sbrg_pos_t got, int i);
    total_checks++;
    if (got !== {4'(i / 10), 4'(i % 10)}) begin
      error_cnt++;
      $display("Error %0t position got %h expected index %0d", $time, got, i);
    end
  endtask

  // Reference model of the message counter, updated at the sampling edge
  always @(posedge clk) begin
    if (!reset_n) idx = 0;
    else begin
      chk_bit(counter_reset, char_read_done && idx == len_of(msg_length) - 1);
      if (char_read_done === 1'b1) begin
        chars++;
        // Counter also wraps after the 80th slot when the length shrank below it
        idx = (idx == len_of(msg_length) - 1 || idx == 79) ? 0 : idx + 1;
      end
    end
  end

  always @(negedge clk) begin
    slow <= 2'(rnd());
    chk_pos(position, idx);
  end

  task automatic pulse(input bit is_step, input int hold);
    if (is_step) step_request_input = 1'b1;
    else burst_request_input = 1'b1;
    repeat (hold) @(negedge clk);
    step_request_input = 1'b0;
    burst_request_input = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic wait_chars(int n);
    for (int k = 0; k < 1000 && chars < n; k++) @(negedge clk);
    repeat (4) @(negedge clk);
    chk_int(chars, n);
    chk_bit(readout_permit_gate, 1'b0);
  endtask

  initial begin
    int n;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    // Held-high steps of random length must each give one character
    for (int i = 0; i < 3; i++) begin
      n = chars + 1;
      pulse(1'b1, 2 + int'(rnd() % 4));
      wait_chars(n);
    end
    n = chars;
    pulse(1'b0, 2);
    wait_chars(n);
    mode = sbrg_pkg::SBRG_MODE_BURST;
    @(negedge clk);
    pulse(1'b1, 2);
    wait_chars(n);
    // First burst resumes from the position the steps left behind
    for (int i = -1; i < 6; i++) begin
      if (i >= 0) msg_length = lens[i];
      n = chars + len_of(msg_length) - idx;
      pulse(1'b0, 3);
      wait_chars(n);
    end
    // Power-up reset inside a message drops the permit and zeroes the count
    pulse(1'b0, 3);
    repeat (8) @(negedge clk);
    reset_n = 1'b0;
    repeat (5) @(negedge clk);
    chk_bit(readout_permit_gate, 1'b0);
    chk_pos(position, 0);
    reset_n = 1'b1;
    n = chars;
    repeat (20) @(negedge clk);
    chk_int(chars, n);
    // Next burst starts again from the first character
    n = chars + len_of(msg_length);
    pulse(1'b0, 3);
    wait_chars(n);
    end_sim();
  end

  initial begin
    // Clean run needs under two thousand cycles; allow about five times that
    #200us;
    error_cnt++;
    end_sim();
  end
endmodule // sbrg_gate_test
`default_nettype wire
